// >>> core/mbpa_pkg.sv
// mbpa_pkg: constants shared by the memory bus ends and their interface.
// assumes one 10 MHz system clock for every user of these values.
package mbpa_pkg;
  localparam int PROG_AW = 22;
  localparam int DATA_AW = 32;
  localparam int DW = 32;
  localparam int NKIND = 5;
  localparam int NREG = 4;
  localparam int WAIT_W = 4;
  localparam int RAM_IW = 6;
  localparam int RAM_WORDS = 64;
  localparam int PAGE_LSB = 3;
  localparam int REG_LSB = 20;

  // access kinds, index order is also priority order (0 highest)
  localparam int K_DWR = 0;
  localparam int K_PWR = 1;
  localparam int K_DRD = 2;
  localparam int K_PRD = 3;
  localparam int K_FETCH = 4;

  // target regions, picked by address bits 21:20
  localparam logic [1:0] REG_RAM0 = 2'h0;
  localparam logic [1:0] REG_RAM1 = 2'h1;
  localparam logic [1:0] REG_ROM = 2'h2;
  localparam logic [1:0] REG_OTP = 2'h3;

  // access times and clock period in ns
  localparam int CLK_PERIOD_NS = 100;
  localparam int PAGE_ACCESS_NS = 19;
  localparam int RAND_ACCESS_NS = 19;
  localparam int OTP_ACCESS_NS = 60;
  localparam int PAGE_FLOOR = 0;
  localparam int RAND_FLOOR = 1;

  // ceil(t / period) - 1, never below the floor
  function automatic int mbpa_waits(input int ns, input int floor);
    int w;
    w = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1;
    return (w < floor) ? floor : w;
  endfunction : mbpa_waits

  localparam logic [WAIT_W-1:0] PAGE_WAIT =
    WAIT_W'(mbpa_waits(PAGE_ACCESS_NS, PAGE_FLOOR));
  localparam logic [WAIT_W-1:0] RAND_WAIT =
    WAIT_W'(mbpa_waits(RAND_ACCESS_NS, RAND_FLOOR));
  localparam logic [WAIT_W-1:0] OTP_WAIT =
    WAIT_W'(mbpa_waits(OTP_ACCESS_NS, RAND_FLOOR));

  // read pattern of the rom regions, mixed with the word address
  localparam logic [DW-1:0] ROM_SEED = 32'hA5C3_0000;
endpackage : mbpa_pkg

// >>> core/mbpa_bus_if.sv
// mbpa_bus_if: the memory bus between processor core and memory side.
// assumes both ends share clk; requests hold until their ack pulse.
`timescale 1ns/100ps
interface mbpa_bus_if;
  logic fetchReq;
  logic progRdReq;
  logic [mbpa_pkg::PROG_AW-1:0] progAddr;
  logic [mbpa_pkg::DW-1:0] progRdData;
  logic progAck;
  logic dataRdReq;
  logic [mbpa_pkg::DATA_AW-1:0] dataRdAddr;
  logic [mbpa_pkg::DW-1:0] dataRdData;
  logic dataRdAck;
  logic dataWrReq;
  logic progWrReq;
  logic [mbpa_pkg::DATA_AW-1:0] dataWrAddr;
  logic [mbpa_pkg::DW-1:0] wrData;
  logic wrAck;
  logic [mbpa_pkg::WAIT_W-1:0] pageWait;
  logic [mbpa_pkg::WAIT_W-1:0] randWait;

  modport core_end (
    output fetchReq, progRdReq, progAddr, dataRdReq, dataRdAddr,
    output dataWrReq, progWrReq, dataWrAddr, wrData, pageWait, randWait,
    input progRdData, progAck, dataRdData, dataRdAck, wrAck
  );
  modport mem_end (
    input fetchReq, progRdReq, progAddr, dataRdReq, dataRdAddr,
    input dataWrReq, progWrReq, dataWrAddr, wrData, pageWait, randWait,
    output progRdData, progAck, dataRdData, dataRdAck, wrAck
  );
endinterface : mbpa_bus_if

// >>> core/mbpa_core_end.sv
// mbpa_core_end: processor side, queues one command per access kind.
// assumes the user holds cmdAddr and write values while cmdBusy is high.
`timescale 1ns/100ps
module mbpa_core_end (
  input wire logic clk,
  input wire logic rst_n,
  mbpa_bus_if.core_end bus,
  input wire logic [mbpa_pkg::NKIND-1:0] cmdStart,
  input wire logic [mbpa_pkg::NKIND-1:0][mbpa_pkg::DATA_AW-1:0] cmdAddr,
  input wire logic [mbpa_pkg::DW-1:0] dataWrValue,
  input wire logic [mbpa_pkg::DW-1:0] progWrValue,
  output logic [mbpa_pkg::NKIND-1:0] cmdBusy,
  output logic [mbpa_pkg::NKIND-1:0] cmdDone,
  output logic [mbpa_pkg::DW-1:0] dataRdValue,
  output logic [mbpa_pkg::DW-1:0] progRdValue
);
  logic [mbpa_pkg::NKIND-1:0] doneNow;
  logic [mbpa_pkg::NKIND-1:0] next_busy;
  logic nDwr, nPwr, nPrd, nFetch;
  logic [mbpa_pkg::DW-1:0] next_dataRd, next_progRd;

  // which presented request the shared acks belong to
  always_comb
  begin
    doneNow = '0;
    doneNow[mbpa_pkg::K_DWR] = bus.wrAck & bus.dataWrReq;
    doneNow[mbpa_pkg::K_PWR] = bus.wrAck & bus.progWrReq;
    doneNow[mbpa_pkg::K_DRD] = bus.dataRdAck & bus.dataRdReq;
    doneNow[mbpa_pkg::K_PRD] = bus.progAck & bus.progRdReq;
    doneNow[mbpa_pkg::K_FETCH] = bus.progAck & bus.fetchReq;
  end

  // per kind: a new command is taken only while idle
  for (genvar k = 0; k < mbpa_pkg::NKIND; k++)
  begin : g_kind
    assign next_busy[k] = cmdBusy[k] ? ~doneNow[k] : cmdStart[k];
  end

  // exclusion of paired kinds; a presented request is never swapped out,
  // else a stalled transfer could be changed under the memory's feet
  always_comb
  begin
    nDwr = next_busy[mbpa_pkg::K_DWR] & ~(bus.progWrReq & ~bus.wrAck);
    nPwr = next_busy[mbpa_pkg::K_PWR] & ~nDwr;
    nPrd = next_busy[mbpa_pkg::K_PRD] & ~(bus.fetchReq & ~bus.progAck);
    nFetch = next_busy[mbpa_pkg::K_FETCH] & ~nPrd;
    next_dataRd = doneNow[mbpa_pkg::K_DRD] ? bus.dataRdData : dataRdValue;
    next_progRd = (doneNow[mbpa_pkg::K_PRD] | doneNow[mbpa_pkg::K_FETCH])
                  ? bus.progRdData : progRdValue;
  end

  // request, address and result registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmdBusy <= '0;
      cmdDone <= '0;
      dataRdValue <= '0;
      progRdValue <= '0;
      bus.dataWrReq <= 1'b0;
      bus.progWrReq <= 1'b0;
      bus.dataRdReq <= 1'b0;
      bus.progRdReq <= 1'b0;
      bus.fetchReq <= 1'b0;
      bus.progAddr <= '0;
      bus.dataRdAddr <= '0;
      bus.dataWrAddr <= '0;
      bus.wrData <= '0;
      bus.pageWait <= mbpa_pkg::PAGE_WAIT;
      bus.randWait <= mbpa_pkg::RAND_WAIT;
    end
    else
    begin
      cmdBusy <= next_busy;
      cmdDone <= doneNow;
      dataRdValue <= next_dataRd;
      progRdValue <= next_progRd;
      bus.dataWrReq <= nDwr;
      bus.progWrReq <= nPwr;
      bus.dataRdReq <= next_busy[mbpa_pkg::K_DRD];
      bus.progRdReq <= nPrd;
      bus.fetchReq <= nFetch;
      bus.progAddr <= nPrd ? cmdAddr[mbpa_pkg::K_PRD][mbpa_pkg::PROG_AW-1:0]
                           : cmdAddr[mbpa_pkg::K_FETCH][mbpa_pkg::PROG_AW-1:0];
      bus.dataRdAddr <= cmdAddr[mbpa_pkg::K_DRD];
      bus.dataWrAddr <= nDwr ? cmdAddr[mbpa_pkg::K_DWR]
                             : cmdAddr[mbpa_pkg::K_PWR];
      bus.wrData <= nDwr ? dataWrValue : progWrValue;
      bus.pageWait <= mbpa_pkg::PAGE_WAIT;
      bus.randWait <= mbpa_pkg::RAND_WAIT;
    end
  end
endmodule : mbpa_core_end

// >>> core/mbpa_mem_end.sv
// mbpa_mem_end: memory side of the bus, four regions with arbitration.
// assumes requests stay stable until acked and drop the cycle after ack.
`timescale 1ns/100ps
module mbpa_mem_end (
  input wire logic clk,
  input wire logic rst_n,
  mbpa_bus_if.mem_end bus,
  output logic [mbpa_pkg::NREG-1:0] regionBusy
);
  localparam int AW = mbpa_pkg::PROG_AW;
  localparam int NK = mbpa_pkg::NKIND;
  localparam int NR = mbpa_pkg::NREG;
  localparam int WW = mbpa_pkg::WAIT_W;
  localparam int PW = AW - mbpa_pkg::PAGE_LSB;

  // two single-port ram regions; the rom regions read a fixed pattern
  logic [mbpa_pkg::DW-1:0] ram0 [mbpa_pkg::RAM_WORDS];
  logic [mbpa_pkg::DW-1:0] ram1 [mbpa_pkg::RAM_WORDS];

  logic [NK-1:0] req;
  logic [NK-1:0] eligible;
  logic [NK-1:0][AW-1:0] reqAddr;
  logic [NK-1:0][1:0] reqReg;
  logic [NK-1:0] done;

  logic [NR-1:0] active;
  logic [NR-1:0][WW-1:0] cnt;
  logic [NR-1:0][2:0] owner;
  logic [NR-1:0][PW-1:0] lastPage;
  logic [NR-1:0] pageValid;
  logic [NR-1:0] next_active;
  logic [NR-1:0][WW-1:0] next_cnt;
  logic [NR-1:0][2:0] next_owner;
  logic [NR-1:0][PW-1:0] next_lastPage;
  logic [NR-1:0] next_pageValid;
  logic [NR-1:0] regDone;
  logic [NR-1:0][2:0] regKind;

  logic next_progAck, next_dataRdAck, next_wrAck;
  logic [mbpa_pkg::DW-1:0] next_progRdData, next_dataRdData;
  logic ram0We, ram1We;
  logic [mbpa_pkg::RAM_IW-1:0] ram0Idx, ram1Idx;

  // read word of a region at an address
  function automatic logic [mbpa_pkg::DW-1:0] readWord(
    input logic [1:0] rg,
    input logic [AW-1:0] a
  );
    logic [mbpa_pkg::RAM_IW-1:0] i;
    i = a[mbpa_pkg::RAM_IW-1:0];
    unique case (rg)
      mbpa_pkg::REG_RAM0: readWord = ram0[i];
      mbpa_pkg::REG_RAM1: readWord = ram1[i];
      mbpa_pkg::REG_ROM: readWord = mbpa_pkg::ROM_SEED ^ {10'h000, a};
      mbpa_pkg::REG_OTP: readWord = ~(mbpa_pkg::ROM_SEED ^ {10'h000, a});
    endcase
  endfunction : readWord

  // wait-states of a rom read; page hits in the rom region use the shorter figure, the otp region never does
  function automatic logic [WW-1:0] romWaits(
    input logic [1:0] rg,
    input logic hit
  );
    logic [WW-1:0] r;
    r = (bus.randWait < WW'(mbpa_pkg::RAND_FLOOR))
        ? WW'(mbpa_pkg::RAND_FLOOR) : bus.randWait;
    if (rg == mbpa_pkg::REG_OTP)
      romWaits = (r < mbpa_pkg::OTP_WAIT) ? mbpa_pkg::OTP_WAIT : r;
    else if (rg == mbpa_pkg::REG_ROM)
      romWaits = hit ? bus.pageWait : r;
    else
      romWaits = '0;
  endfunction : romWaits

  // gather the five requests; a kind whose ack is showing is not seen
  // again, since its request is still up for that one cycle
  always_comb
  begin
    req[mbpa_pkg::K_DWR] = bus.dataWrReq & ~bus.wrAck;
    req[mbpa_pkg::K_PWR] = bus.progWrReq & ~bus.wrAck;
    req[mbpa_pkg::K_DRD] = bus.dataRdReq & ~bus.dataRdAck;
    req[mbpa_pkg::K_PRD] = bus.progRdReq & ~bus.progAck;
    req[mbpa_pkg::K_FETCH] = bus.fetchReq & ~bus.progAck;
    reqAddr[mbpa_pkg::K_DWR] = bus.dataWrAddr[AW-1:0];
    reqAddr[mbpa_pkg::K_PWR] = bus.dataWrAddr[AW-1:0];
    reqAddr[mbpa_pkg::K_DRD] = bus.dataRdAddr[AW-1:0];
    reqAddr[mbpa_pkg::K_PRD] = bus.progAddr;
    reqAddr[mbpa_pkg::K_FETCH] = bus.progAddr;
    // both writes share one ack, so a clash is dropped to the data write
    eligible = req;
    if (req[mbpa_pkg::K_DWR])
      eligible[mbpa_pkg::K_PWR] = 1'b0;
    if (req[mbpa_pkg::K_PRD])
      eligible[mbpa_pkg::K_FETCH] = 1'b0;
  end

  // one arbiter and wait counter per region, each independent so that
  // accesses to different regions finish in the same cycle
  for (genvar r = 0; r < NR; r++)
  begin : g_region
    logic found;
    logic [2:0] win;
    logic hit;
    logic [WW-1:0] w;
    always_comb
    begin
      found = 1'b0;
      win = 3'h0;
      // lowest index wins; higher kinds simply wait their turn
      for (int k = NK - 1; k >= 0; k--)
        if (eligible[k] && reqAddr[k][AW-1:mbpa_pkg::REG_LSB] == 2'(r))
        begin
          found = 1'b1;
          win = 3'(k);
        end
      hit = pageValid[r] &&
            lastPage[r] == reqAddr[win][AW-1:mbpa_pkg::PAGE_LSB];
      w = (win <= 3'(mbpa_pkg::K_PWR)) ? '0 : romWaits(2'(r), hit);
      next_active[r] = active[r];
      next_cnt[r] = cnt[r];
      next_owner[r] = owner[r];
      next_lastPage[r] = lastPage[r];
      next_pageValid[r] = pageValid[r];
      regDone[r] = 1'b0;
      regKind[r] = owner[r];
      if (active[r])
      begin
        // the owner keeps the region until its wait-states run out
        if (cnt[r] == WW'(1))
        begin
          next_active[r] = 1'b0;
          regDone[r] = 1'b1;
        end
        next_cnt[r] = cnt[r] - WW'(1);
      end
      else if (found)
      begin
        if (w != '0)
        begin
          next_active[r] = 1'b1;
          next_cnt[r] = w;
          next_owner[r] = win;
        end
        else
        begin
          regDone[r] = 1'b1;
          regKind[r] = win;
        end
        if (win > 3'(mbpa_pkg::K_PWR))
        begin
          next_lastPage[r] = reqAddr[win][AW-1:mbpa_pkg::PAGE_LSB];
          next_pageValid[r] = 1'b1;
        end
      end
    end
  end

  // completions back to kinds; anything not done stays stalled as is
  always_comb
  begin
    done = '0;
    for (int r = 0; r < NR; r++)
      if (regDone[r])
        done[regKind[r]] = 1'b1;
    next_wrAck = done[mbpa_pkg::K_DWR] | done[mbpa_pkg::K_PWR];
    next_dataRdAck = done[mbpa_pkg::K_DRD];
    next_progAck = done[mbpa_pkg::K_PRD] | done[mbpa_pkg::K_FETCH];
    next_dataRdData = bus.dataRdData;
    next_progRdData = bus.progRdData;
    if (next_dataRdAck)
      next_dataRdData = readWord(reqReg[mbpa_pkg::K_DRD],
                                 reqAddr[mbpa_pkg::K_DRD]);
    if (done[mbpa_pkg::K_PRD] || done[mbpa_pkg::K_FETCH])
      next_progRdData = readWord(reqReg[mbpa_pkg::K_PRD],
                                 reqAddr[mbpa_pkg::K_PRD]);
  end

  // writes land only in ram; writes to rom are acked and dropped
  always_comb
  begin
    for (int k = 0; k < NK; k++)
      reqReg[k] = reqAddr[k][AW-1:mbpa_pkg::REG_LSB];
    ram0We = regDone[mbpa_pkg::REG_RAM0] &&
             regKind[mbpa_pkg::REG_RAM0] <= 3'(mbpa_pkg::K_PWR);
    ram1We = regDone[mbpa_pkg::REG_RAM1] &&
             regKind[mbpa_pkg::REG_RAM1] <= 3'(mbpa_pkg::K_PWR);
    ram0Idx = bus.dataWrAddr[mbpa_pkg::RAM_IW-1:0];
    ram1Idx = bus.dataWrAddr[mbpa_pkg::RAM_IW-1:0];
  end

  // memory arrays carry no reset, contents are undefined at power-up
  always_ff @(posedge clk)
  begin
    if (ram0We)
      ram0[ram0Idx] <= bus.wrData;
    if (ram1We)
      ram1[ram1Idx] <= bus.wrData;
  end

  // region state and bus answers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active <= '0;
      cnt <= '0;
      owner <= '0;
      lastPage <= '0;
      pageValid <= '0;
      regionBusy <= '0;
      bus.wrAck <= 1'b0;
      bus.dataRdAck <= 1'b0;
      bus.progAck <= 1'b0;
      bus.dataRdData <= '0;
      bus.progRdData <= '0;
    end
    else
    begin
      active <= next_active;
      cnt <= next_cnt;
      owner <= next_owner;
      lastPage <= next_lastPage;
      pageValid <= next_pageValid;
      regionBusy <= next_active;
      bus.wrAck <= next_wrAck;
      bus.dataRdAck <= next_dataRdAck;
      bus.progAck <= next_progAck;
      bus.dataRdData <= next_dataRdData;
      bus.progRdData <= next_progRdData;
    end
  end
endmodule : mbpa_mem_end

// >>> verif/mbpa_bus_monitor.sv
// mbpa_bus_monitor: assertions on the bus joining the two ends.
// assumes one clock and the interface signals wired in by tb_top.
`timescale 1ns/100ps
module mbpa_bus_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fetchReq,
  input wire logic progRdReq,
  input wire logic [mbpa_pkg::PROG_AW-1:0] progAddr,
  input wire logic progAck,
  input wire logic dataRdReq,
  input wire logic [mbpa_pkg::DATA_AW-1:0] dataRdAddr,
  input wire logic dataRdAck,
  input wire logic dataWrReq,
  input wire logic progWrReq,
  input wire logic [mbpa_pkg::WAIT_W-1:0] pageWait,
  input wire logic [mbpa_pkg::WAIT_W-1:0] randWait
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // write kinds share one path, so never both at once
  AST_WR_EXCL: assert property (
    !(dataWrReq && progWrReq))
    else $error("both write kinds presented");
  // program read and fetch share the program read path
  AST_RD_EXCL: assert property (
    !(progRdReq && fetchReq))
    else $error("program read and fetch presented");
  // ack only for a live program request, and only one cycle
  AST_PACK_CAUSE: assert property (
    progAck |-> (progRdReq || fetchReq) && $past(progRdReq || fetchReq)
      ##1 !progAck)
    else $error("program ack without request");
  // a stalled program request keeps its address
  AST_PROG_HOLD: assert property (
    (progRdReq || fetchReq) && !progAck |=>
      (progRdReq || fetchReq) && $stable(progAddr))
    else $error("program request changed before ack");
  // a stalled data read keeps its address
  AST_DRD_HOLD: assert property (
    dataRdReq && !dataRdAck |=> dataRdReq && $stable(dataRdAddr))
    else $error("data read changed before ack");
  // contention only delays a read by a few grants
  AST_DRD_BOUND: assert property (
    $rose(dataRdReq) |-> ##[1:12] dataRdAck)
    else $error("data read never acked");
  // the slow rom block cannot answer without a wait-state
  AST_OTP_SLOW: assert property (
    $rose(dataRdReq) && dataRdAddr[21:20] == 2'h3 |=> !dataRdAck)
    else $error("otp area read answered too soon");
  // wait config at 10 MHz is page 0, random 1
  AST_WAIT_CFG: assert property (
    pageWait == 4'h0 && randWait == 4'h1)
    else $error("wait config wrong");
endmodule : mbpa_bus_monitor

// >>> verif/tb_top.sv
// tb_top: drives the core end user side, checks data and timing.
// assumes core and memory ends meet through one bus interface.
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] cmdStart = '0;
  logic [4:0][31:0] cmdAddr = '0;
  logic [31:0] dataWrValue = '0;
  logic [31:0] progWrValue = '0;
  logic [4:0] cmdBusy;
  logic [4:0] cmdDone;
  logic [31:0] dataRdValue;
  logic [31:0] progRdValue;
  logic [3:0] regionBusy;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int doneAt [5];
  logic [3:0] busySeen;

  mbpa_bus_if mbpa_bus_if_i ();
  mbpa_core_end mbpa_core_end_i (.clk(clk), .rst_n(rst_n),
    .bus(mbpa_bus_if_i), .cmdStart(cmdStart), .cmdAddr(cmdAddr),
    .dataWrValue(dataWrValue), .progWrValue(progWrValue),
    .cmdBusy(cmdBusy), .cmdDone(cmdDone), .dataRdValue(dataRdValue),
    .progRdValue(progRdValue));
  mbpa_mem_end mbpa_mem_end_i (.clk(clk), .rst_n(rst_n),
    .bus(mbpa_bus_if_i), .regionBusy(regionBusy));
  mbpa_bus_monitor mbpa_bus_monitor_i (.clk(clk), .rst_n(rst_n),
    .fetchReq(mbpa_bus_if_i.fetchReq),
    .progRdReq(mbpa_bus_if_i.progRdReq),
    .progAddr(mbpa_bus_if_i.progAddr), .progAck(mbpa_bus_if_i.progAck),
    .dataRdReq(mbpa_bus_if_i.dataRdReq),
    .dataRdAddr(mbpa_bus_if_i.dataRdAddr),
    .dataRdAck(mbpa_bus_if_i.dataRdAck),
    .dataWrReq(mbpa_bus_if_i.dataWrReq),
    .progWrReq(mbpa_bus_if_i.progWrReq),
    .pageWait(mbpa_bus_if_i.pageWait), .randWait(mbpa_bus_if_i.randWait));

  // 10 MHz system clock
  always #50 clk = ~clk;

  // hang guard: whole run takes under two hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      $display("Error %0t: run did not finish", $time);
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // start the kinds in mask on one edge, note the edge each one ends;
  // a fixed window keeps a missing done visible as zero
  // regions seen in wait-states are gathered in busySeen
  task automatic go(input logic [4:0] mask);
    int n;
    doneAt = '{default: 0};
    busySeen = '0;
    cmdStart = mask;
    @(posedge clk);
    #1 cmdStart = '0;
    check(32'(cmdBusy), 32'(mask));
    for (n = 1; n <= 20; n++)
    begin
      @(posedge clk);
      #1;
      busySeen = busySeen | regionBusy;
      for (int k = 0; k < 5; k++)
        if (cmdDone[k] === 1'b1 && doneAt[k] == 0)
          doneAt[k] = n;
    end
    check(32'(cmdBusy), 32'h0);
  endtask : go

  // a no-wait access is done 2 edges after the take, one wait-state
  // makes it 3; a loser adds one edge per grant ahead of it
  initial
  begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    check(32'(mbpa_bus_if_i.pageWait), 32'h0);
    check(32'(mbpa_bus_if_i.randWait), 32'h1);
    // write, read and fetch fight for ram0 word 5
    cmdAddr[0] = 32'h0000_0005;
    cmdAddr[2] = 32'h0000_0005;
    cmdAddr[4] = 32'h0000_0005;
    dataWrValue = 32'h1234_ABCD;
    go(5'h15);
    check(32'(doneAt[0]), 32'h2);
    check(32'(busySeen), 32'h0);
    check(32'(doneAt[0] < doneAt[2]), 32'h1);
    check(32'(doneAt[2] < doneAt[4]), 32'h1);
    check(dataRdValue, 32'h1234_ABCD);
    check(progRdValue, 32'h1234_ABCD);
    // program write, data read and program read fight for ram1
    cmdAddr[1] = 32'h0010_0007;
    cmdAddr[2] = 32'h0010_0007;
    cmdAddr[3] = 32'h0010_0007;
    progWrValue = 32'hC0DE_0F0F;
    go(5'h0E);
    check(32'(doneAt[1]), 32'h2);
    check(32'(doneAt[1] < doneAt[2]), 32'h1);
    check(32'(doneAt[2] < doneAt[3]), 32'h1);
    check(dataRdValue, 32'hC0DE_0F0F);
    check(progRdValue, 32'hC0DE_0F0F);
    // first rom read opens a page with one random wait-state
    cmdAddr[3] = 32'h0020_0010;
    go(5'h08);
    check(32'(doneAt[3]), 32'h3);
    check(32'(busySeen), 32'h4);
    check(progRdValue, 32'hA5E3_0010);
    // three buses, three resources, one cycle; fetch is a page hit
    cmdAddr[0] = 32'h0000_0009;
    cmdAddr[4] = 32'h0020_0012;
    dataWrValue = 32'h0F0F_1234;
    go(5'h15);
    check(32'(doneAt[0]), 32'h2);
    check(32'(doneAt[2]), 32'h2);
    check(32'(doneAt[4]), 32'h2);
    check(32'(busySeen), 32'h0);
    check(progRdValue, 32'hA5E3_0012);
    check(dataRdValue, 32'hC0DE_0F0F);
    // slow rom block needs its wait-state, data is inverted pattern
    cmdAddr[2] = 32'h0030_0004;
    go(5'h04);
    check(32'(doneAt[2]), 32'h3);
    check(32'(busySeen), 32'h8);
    check(dataRdValue, 32'h5A0C_FFFB);
    // earlier write to ram0 word 9 survived the concurrent cycle
    cmdAddr[2] = 32'h0000_0009;
    go(5'h04);
    check(dataRdValue, 32'h0F0F_1234);
    // both writes and both program reads at once: the core end must
    // serialise each pair, the later one waiting for the first ack
    cmdAddr[0] = 32'h0000_0011;
    cmdAddr[1] = 32'h0010_0012;
    cmdAddr[3] = 32'h0000_0011;
    cmdAddr[4] = 32'h0010_0012;
    dataWrValue = 32'h1111_2222;
    progWrValue = 32'h3333_4444;
    go(5'h1B);
    check(32'(doneAt[0]), 32'h2);
    check(32'(doneAt[3]), 32'h3);
    check(32'(doneAt[1]), 32'h4);
    check(32'(doneAt[4]), 32'h5);
    check(progRdValue, 32'h3333_4444);
    check(32'(busySeen), 32'h0);
    close_out();
  end
endmodule : tb_top
